// File: hdl/pbc_pkg.sv
// Package for the basic mode control register bank
// Overview of operation
// RL1 - Writing 1 to bit 15 starts a port soft reset; it reads 1 while running and then self-clears.
// RL2 - When the soft reset completes, configuration reloads from the latched strap values.
// RL3 - Bit 14 set routes transmit data back into the receive path; default 0.
// RL4 - After loopback is enabled the receive side shows no valid data for up to 500 us.
// RL5 - With auto-negotiation off, bit 13 picks speed: 1 is 100 Mb/s, 0 is 10 Mb/s; reset from strap.
// RL6 - Bit 12 enables auto-negotiation; it starts from its strap and is then read/write.
// RL7 - With fiber mode enabled, bit 12 resets to 0 whatever the strap says.
// RL8 - While auto-negotiation is on, the speed and duplex bits are ignored for the operating mode.
// RL9 - A latched-high status bit goes to 1 on its event, holds until read, then tracks the state.
// RL10 - A latched-low status bit goes to 0 on its event, holds until read, then tracks the state.
// RL11 - A clear-on-read field returns its value and is cleared by that same read.
// RL12 - An event self-clearing field is set by its event and clears when the event ends.
// RL13 - A fixed read-only field always returns its default and ignores writes.
// RL14 - With auto-negotiation off, bit 8 picks duplex: 1 full, 0 half; reset from strap.
package pbc_pkg;
  localparam logic [31:0] ADDR_CONTROL  = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS   = 32'h0000_0004;
  localparam logic [31:0] ADDR_EVENTS   = 32'h0000_0008;
  localparam logic [31:0] ADDR_FIXED    = 32'h0000_000C;
  localparam int          BIT_RESET     = 15;
  localparam int          BIT_LOOPBACK  = 14;
  localparam int          BIT_SPEED     = 13;
  localparam int          BIT_AUTONEG   = 12;
  localparam int          BIT_DUPLEX    = 8;
  localparam logic [15:0] FIXED_VALUE   = 16'h0A5C; // arbitrary
  localparam int          CLK_MHZ       = 200;
  localparam int          DEAD_TIME_US  = 500;
  localparam int          DEAD_CYCLES   = DEAD_TIME_US * CLK_MHZ;
  localparam int          SRST_CYCLES   = 16;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic autoneg_en;
  } pbc_straps_t;
  typedef struct packed {
    logic autoneg_active;
    logic speed_100;
    logic full_duplex;
    logic loopback;
    logic rx_valid;
    logic port_reset;
  } pbc_mode_t;
endpackage

// File: hdl/pbc_control.sv
// Basic mode control register bank with an AXI4-Lite slave
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module pbc_control
  import pbc_pkg::*;
#(
  parameter int DEAD_TIME_CYCLES = DEAD_CYCLES,
  parameter int SOFT_RESET_CYCLES = SRST_CYCLES
)
(
  // Clock, reset, enable
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_clk_en,
  // Straps and status pins
  input  wire pbc_straps_t i_straps,
  input  wire logic        i_fiber_mode_enable,
  input  wire logic        i_link_up,
  input  wire logic        i_rx_error,
  input  wire logic        i_energy_event,
  input  wire logic        i_fault_event,
  // AXI4-Lite write
  input  wire logic [31:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // AXI4-Lite read
  input  wire logic [31:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Operating mode to the core
  output pbc_mode_t        o_mode
);
  initial
  begin
    if (DEAD_TIME_CYCLES < 1 || SOFT_RESET_CYCLES < 1)
      $error("pbc_control: counts must be at least one");
  end

  // Pin synchronisers, two flops before use
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [5:0] next_sync1;
  logic       s_fiber;
  logic       s_link;
  logic       s_rxerr;
  logic       s_energy;
  logic       s_fault;
  logic       s_spd;
  always_comb
  begin
    next_sync1 = {i_fiber_mode_enable, i_link_up, i_rx_error,
                  i_energy_event, i_fault_event, 1'b0};
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else if (i_clk_en)
    begin
      sync1 <= next_sync1;
      sync2 <= sync1;
    end
  end
  assign {s_fiber, s_link, s_rxerr, s_energy, s_fault, s_spd} = sync2;

  // Strap latches, captured in the cycle after release
  logic        strap_take;
  // Load one cycle after the latch so the fresh straps are used
  logic        strap_load;
  pbc_straps_t straps_q;
  logic        fiber_q;

  // Register state
  logic        srst_busy;
  logic        loopback;
  logic        speed;
  logic        autoneg;
  logic        duplex;
  logic [31:0] srst_cnt;
  logic [31:0] dead_cnt;
  logic        link_lh_low;
  logic        err_lh_high;
  logic [7:0]  err_count;
  logic        next_srst_busy;
  logic        next_loopback;
  logic        next_speed;
  logic        next_autoneg;
  logic        next_duplex;
  logic [31:0] next_srst_cnt;
  logic [31:0] next_dead_cnt;
  logic        next_link_lh_low;
  logic        next_err_lh_high;
  logic [7:0]  next_err_count;

  // Bus state
  logic        aw_held;
  logic        w_held;
  logic [31:0] aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        rvalid;
  logic [1:0]  rresp;
  logic [31:0] rdata;
  logic        next_aw_held;
  logic        next_w_held;
  logic [31:0] next_aw_q;
  logic [31:0] next_w_q;
  logic [3:0]  next_ws_q;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [1:0]  next_rresp;
  logic [31:0] next_rdata;

  logic        wr_do;
  logic        rd_do;
  logic [31:0] wa;
  logic [31:0] wd;
  logic [3:0]  wsel;
  logic [15:0] ctrl_view;
  logic [15:0] stat_view;
  logic        reload;

  assign o_awready = !aw_held && !bvalid;
  assign o_wready  = !w_held && !bvalid;
  assign o_arready = !rvalid;
  assign wa   = aw_held ? aw_q : i_awaddr;
  assign wd   = w_held ? w_q : i_wdata;
  assign wsel = w_held ? ws_q : i_wstrb;
  assign wr_do = (aw_held || i_awvalid) && (w_held || i_wvalid) && !bvalid;
  assign rd_do = i_arvalid && !rvalid;
  // Reload after power-up or at soft reset end
  assign reload = strap_load || (srst_busy && srst_cnt == 32'h0000_0001); // RL2

  always_comb
  begin
    ctrl_view = 16'h0000;
    ctrl_view[BIT_RESET]    = srst_busy; // RL1
    ctrl_view[BIT_LOOPBACK] = loopback;
    ctrl_view[BIT_SPEED]    = speed;
    ctrl_view[BIT_AUTONEG]  = autoneg;
    ctrl_view[BIT_DUPLEX]   = duplex;
    stat_view = {12'h000, (dead_cnt != 32'h0000_0000), s_energy,
                 link_lh_low, err_lh_high};
  end

  // Register next state
  always_comb
  begin
    next_srst_busy   = srst_busy;
    next_loopback    = loopback;
    next_speed       = speed;
    next_autoneg     = autoneg;
    next_duplex      = duplex;
    next_srst_cnt    = srst_cnt;
    next_dead_cnt    = dead_cnt;
    next_link_lh_low = link_lh_low;
    next_err_lh_high = err_lh_high;
    next_err_count   = err_count;
    // Soft reset countdown
    if (srst_busy)
    begin
      next_srst_cnt = srst_cnt - 32'h0000_0001;
      if (srst_cnt == 32'h0000_0001)
        next_srst_busy = 1'b0; // RL1
    end
    if (dead_cnt != 32'h0000_0000)
      next_dead_cnt = dead_cnt - 32'h0000_0001; // RL4
    // Read side effects first; events below win over the clear
    if (rd_do && i_araddr == ADDR_STATUS)
    begin
      next_link_lh_low = s_link; // RL10
      next_err_lh_high = s_rxerr; // RL9
    end
    if (rd_do && i_araddr == ADDR_EVENTS)
      next_err_count = 8'h00; // RL11
    if (!s_link)
      next_link_lh_low = 1'b0; // RL10
    if (s_rxerr)
      next_err_lh_high = 1'b1; // RL9
    if (s_fault && next_err_count != 8'hFF)
      next_err_count = next_err_count + 8'h01; // RL11
    if (wr_do && wa == ADDR_CONTROL && !srst_busy)
    begin
      if (wsel[1])
      begin
        next_speed   = wd[BIT_SPEED]; // RL5
        next_autoneg = wd[BIT_AUTONEG]; // RL6
        if (wd[BIT_LOOPBACK] && !loopback)
          next_dead_cnt = 32'(DEAD_TIME_CYCLES); // RL4
        next_loopback = wd[BIT_LOOPBACK]; // RL3
        if (wd[BIT_RESET])
        begin
          next_srst_busy = 1'b1; // RL1
          next_srst_cnt  = 32'(SOFT_RESET_CYCLES);
        end
      end
      if (wsel[0] || wsel[1])
        next_duplex = wsel[1] ? wd[BIT_DUPLEX] : duplex; // RL14
    end
    if (reload)
    begin
      next_loopback = 1'b0;
      next_speed    = straps_q.speed_100; // RL5
      next_duplex   = straps_q.full_duplex; // RL14
      next_autoneg  = straps_q.autoneg_en && !fiber_q; // RL7
      next_dead_cnt = 32'h0000_0000;
    end
  end

  // Bus next state
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_q    = aw_q;
    next_w_q     = w_q;
    next_ws_q    = ws_q;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    if (o_awready && i_awvalid && !wr_do)
    begin
      next_aw_held = 1'b1;
      next_aw_q    = i_awaddr;
    end
    if (o_wready && i_wvalid && !wr_do)
    begin
      next_w_held = 1'b1;
      next_w_q    = i_wdata;
      next_ws_q   = i_wstrb;
    end
    if (wr_do)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      // Fixed word ignores writes but answers OKAY
      next_bresp = (wa == ADDR_CONTROL || wa == ADDR_STATUS ||
                    wa == ADDR_EVENTS || wa == ADDR_FIXED)
                   ? RESP_OKAY : RESP_SLVERR; // RL13
    end
    if (bvalid && i_bready)
      next_bvalid = 1'b0;
    if (rd_do)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      case (i_araddr)
        ADDR_CONTROL: next_rdata = {16'h0000, ctrl_view};
        ADDR_STATUS:  next_rdata = {16'h0000, stat_view}; // RL12
        ADDR_EVENTS:  next_rdata = {24'h00_0000, err_count}; // RL11
        ADDR_FIXED:   next_rdata = {16'h0000, FIXED_VALUE}; // RL13
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid && i_rready)
      next_rvalid = 1'b0;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      strap_take  <= 1'b1;
      strap_load  <= 1'b0;
      straps_q    <= '0;
      fiber_q     <= 1'b0;
      srst_busy   <= 1'b0;
      loopback    <= 1'b0;
      speed       <= 1'b0;
      autoneg     <= 1'b0;
      duplex      <= 1'b0;
      srst_cnt    <= '0;
      dead_cnt    <= '0;
      link_lh_low <= 1'b0;
      err_lh_high <= 1'b0;
      err_count   <= '0;
      aw_held     <= 1'b0;
      w_held      <= 1'b0;
      aw_q        <= '0;
      w_q         <= '0;
      ws_q        <= '0;
      bvalid      <= 1'b0;
      bresp       <= RESP_OKAY;
      rvalid      <= 1'b0;
      rresp       <= RESP_OKAY;
      rdata       <= '0;
    end
    else if (i_clk_en)
    begin
      // Straps are pins, latched once after release
      if (strap_take)
      begin
        straps_q <= i_straps;
        fiber_q  <= i_fiber_mode_enable;
      end
      strap_take  <= 1'b0;
      strap_load  <= strap_take;
      srst_busy   <= next_srst_busy;
      loopback    <= next_loopback;
      speed       <= next_speed;
      autoneg     <= next_autoneg;
      duplex      <= next_duplex;
      srst_cnt    <= next_srst_cnt;
      dead_cnt    <= next_dead_cnt;
      link_lh_low <= next_link_lh_low;
      err_lh_high <= next_err_lh_high;
      err_count   <= next_err_count;
      aw_held     <= next_aw_held;
      w_held      <= next_w_held;
      aw_q        <= next_aw_q;
      w_q         <= next_w_q;
      ws_q        <= next_ws_q;
      bvalid      <= next_bvalid;
      bresp       <= next_bresp;
      rvalid      <= next_rvalid;
      rresp       <= next_rresp;
      rdata       <= next_rdata;
    end
  end

  assign o_bvalid = bvalid;
  assign o_bresp  = bresp;
  assign o_rvalid = rvalid;
  assign o_rresp  = rresp;
  assign o_rdata  = rdata;

  // Mode to the core; autoneg masks speed and duplex
  always_comb
  begin
    o_mode.autoneg_active = autoneg;
    o_mode.speed_100      = autoneg ? 1'b1 : speed; // RL8
    o_mode.full_duplex    = autoneg ? 1'b1 : duplex; // RL8
    o_mode.loopback       = loopback; // RL3
    o_mode.rx_valid       = (dead_cnt == 32'h0000_0000); // RL4
    o_mode.port_reset     = srst_busy;
  end
endmodule

// File: testbench/pbc_props.sv
// Interface checks for the control register bank
`timescale 1ns/100ps
module pbc_props
  import pbc_pkg::*;
(
  // Clock and reset
  input wire logic      i_sys_clk,
  input wire logic      i_rst,
  input wire logic      i_clk_en,
  // Bus handshakes
  input wire logic      i_arvalid,
  input wire logic      i_bready,
  input wire logic      i_rready,
  input wire logic      o_awready,
  input wire logic      o_bvalid,
  input wire logic      o_arready,
  input wire logic      o_rvalid,
  // Core mode
  input wire pbc_mode_t o_mode
);
  // Frozen cycles excluded; state does not move then
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst || !i_clk_en);
  a_bvalid_holds: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("bvalid dropped early");
  a_bvalid_ends: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("bvalid stuck");
  a_rvalid_holds: assert property (o_rvalid && !i_rready |=> o_rvalid)
    else $error("rvalid dropped early");
  a_aw_refused: assert property (o_bvalid |-> !o_awready)
    else $error("write taken under response");
  a_ar_refused: assert property (o_rvalid |-> !o_arready)
    else $error("read taken under response");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  a_autoneg_mode: assert property (o_mode.autoneg_active |->
    o_mode.speed_100 && o_mode.full_duplex) else $error("bits not ignored");
  a_dead_start: assert property ($rose(o_mode.loopback) |->
    ##[0:1] !o_mode.rx_valid) else $error("no dead time");
  a_dead_bound: assert property ($fell(o_mode.rx_valid) |->
    ##[1:30] o_mode.rx_valid) else $error("dead time too long");
  a_srst_bound: assert property ($rose(o_mode.port_reset) |->
    o_mode.port_reset[*8] ##[1:12] !o_mode.port_reset)
    else $error("soft reset length");
  c_loop: cover property ($rose(o_mode.loopback));
  c_srst: cover property ($rose(o_mode.port_reset));
  c_write: cover property (o_bvalid && i_bready);
endmodule

// File: testbench/tb.sv
// Self-checking bench for the control register bank
`timescale 1ns/100ps
module tb;
  import pbc_pkg::*;
  logic        clk = 0, rst = 1, fib = 0, lnk = 1, rxe = 0, eng = 0, flt = 0;
  logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [31:0] awa = 0, wd = 0, ara = 0, rdat;
  logic [1:0]  rrsp;
  logic [1:0]  brsp;
  pbc_straps_t st = '{speed_100: 1'b0, full_duplex: 1'b1, autoneg_en: 1'b1};
  pbc_mode_t   md;
  logic        awr, wr_rdy, bv, arr, rv;
  logic [1:0]  br;
  logic [31:0] rdo;
  int          bad_count = 0, checks_done = 0;
  pbc_control #(.DEAD_TIME_CYCLES(20), .SOFT_RESET_CYCLES(16)) uut (
    .i_sys_clk(clk), .i_rst(rst), .i_clk_en(1'b1), .i_straps(st),
    .i_fiber_mode_enable(fib), .i_link_up(lnk), .i_rx_error(rxe),
    .i_energy_event(eng), .i_fault_event(flt), .i_awaddr(awa),
    .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF),
    .i_wvalid(wv), .o_wready(wr_rdy), .o_bresp(br), .o_bvalid(bv),
    .i_bready(bre), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr),
    .o_rdata(rdo), .o_rresp(), .o_rvalid(rv), .i_rready(rre), .o_mode(md));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hw_reset();
    rst <= 1;
    repeat (12) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
  endtask
  // Write channels released one by one as each is taken
  task automatic wr(input logic [31:0] a, d);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wr_rdy) wv <= 0;
    end while (bv !== 1'b1);
    brsp = br;
    bre <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [31:0] a);
    ara <= a; arv <= 1; rre <= 1;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (rv !== 1'b1);
    rdat = rdo;
    rrsp = uut.o_rresp;
    rre <= 0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [31:0] a, exp);
    rd(a);
    chk("rdata", rdat, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic t_regs();
    rc(ADDR_CONTROL, 32'h0000_1100);
    rc(ADDR_FIXED, {16'h0000, FIXED_VALUE});
    wr(ADDR_FIXED, 32'h0000_0000);
    chk("bresp", {30'h0, brsp}, {30'h0, RESP_OKAY});
    rc(ADDR_FIXED, {16'h0000, FIXED_VALUE});
    rc(32'h0000_0010, 32'h0000_0000);
    chk("rresp", {30'h0, rrsp}, {30'h0, RESP_SLVERR});
  endtask
  task automatic t_status();
    rd(ADDR_STATUS);
    rxe <= 1; wt(2); rxe <= 0; wt(6);
    rc(ADDR_STATUS, 32'h0000_0003);
    rc(ADDR_STATUS, 32'h0000_0002);
    lnk <= 0; wt(2); lnk <= 1; wt(6);
    rc(ADDR_STATUS, 32'h0000_0000);
    rc(ADDR_STATUS, 32'h0000_0002);
    eng <= 1; wt(5);
    rc(ADDR_STATUS, 32'h0000_0006);
    eng <= 0; wt(5);
    rc(ADDR_STATUS, 32'h0000_0002);
    rd(ADDR_EVENTS);
    flt <= 1; wt(5); flt <= 0; wt(5);
    rc(ADDR_EVENTS, 32'h0000_0005);
    rc(ADDR_EVENTS, 32'h0000_0000);
  endtask
  task automatic t_mode();
    wr(ADDR_CONTROL, 32'h0000_2000);
    chk("mode", {29'h0, md.autoneg_active, md.speed_100, md.full_duplex},
      32'h0000_0002);
    wr(ADDR_CONTROL, 32'h0000_0100);
    chk("mode", {29'h0, md.autoneg_active, md.speed_100, md.full_duplex},
      32'h0000_0001);
    wr(ADDR_CONTROL, 32'h0000_1000);
    chk("mode", {29'h0, md.autoneg_active, md.speed_100, md.full_duplex},
      32'h0000_0007);
    rc(ADDR_CONTROL, 32'h0000_1000);
  endtask
  task automatic t_loop();
    wr(ADDR_CONTROL, 32'h0000_4000);
    chk("loop", {30'h0, md.loopback, md.rx_valid}, 32'h0000_0002);
    rc(ADDR_STATUS, 32'h0000_000A);
    wt(30);
    chk("rx_valid", {31'h0, md.rx_valid}, 32'h0000_0001);
  endtask
  // Straps are static, so a reload shows as the strap image returning
  task automatic t_srst();
    wr(ADDR_CONTROL, 32'h0000_C000);
    chk("port_reset", {31'h0, md.port_reset}, 32'h0000_0001);
    rd(ADDR_CONTROL);
    chk("reset bit", {31'h0, rdat[15]}, 32'h0000_0001);
    wt(24);
    rc(ADDR_CONTROL, 32'h0000_1100);
    chk("loop", {31'h0, md.loopback}, 32'h0000_0000);
  endtask
  task automatic t_fiber();
    fib <= 1;
    hw_reset();
    rc(ADDR_CONTROL, 32'h0000_0100);
  endtask
  initial
  begin
    hw_reset();
    t_regs();
    t_status();
    t_mode();
    t_loop();
    t_srst();
    t_fiber();
    results();
  end
  initial
  begin
    #100000;
    bad_count++;
    results();
  end
endmodule
bind pbc_control pbc_props u_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_clk_en(i_clk_en), .i_arvalid(i_arvalid), .i_bready(i_bready),
  .i_rready(i_rready), .o_awready(o_awready), .o_bvalid(o_bvalid),
  .o_arready(o_arready), .o_rvalid(o_rvalid), .o_mode(o_mode));
